/* File: rtl/da_alu_consts.vh */
// Constants for the address generator and accumulator datapath
//
// Overview of operation
// - Direct address is page pointer above offset.
// - Immediate and operandless ops skip direct addressing.
// - Three-bit selector picks one of eight registers.
// - Auxiliary unit does unsigned update in execute.
// - Six post-access updates of selected auxiliary register.
// - Bit-reversed modes carry from top bit downward.
// - Optional new selector loads with address update.
// - Short constant in opcode, long in operand word.
// - Fetch, decode and execute stages overlap.
// - Off-chip operand fetch stretches execute by cycles.
// - Add, subtract, load shift data by count.
// - Carry added, inverted carry subtracted as borrow.
// - Low variants treat data word as unsigned.
// - Temporary register count replaces opcode shift count.
// - Long logic ops touch accumulator bits thirty-zero.
// - Rounded load puts 8000 hex in low half.
// - Low load clears high half, no extension.
// - Short immediate ops use eight-bit opcode constant.
// - Long immediate load shifts constant sixteen places.
// - Absolute value, negate and complement of accumulator.
// - High-half add and subtract shift by sixteen.
// - Stores write shifted half, accumulator kept.
`ifndef DA_ALU_CONSTS_VH
`define DA_ALU_CONSTS_VH
// ==========================================
// Register byte offsets
`define DA_R_CMD    8'h00
`define DA_R_OPND   8'h04
`define DA_R_PAGE   8'h08
`define DA_R_SEL    8'h0C
`define DA_R_TREG   8'h10
`define DA_R_CTRL   8'h14
`define DA_R_STAT   8'h18
`define DA_R_ACC    8'h1C
`define DA_R_ADDR   8'h20
`define DA_R_STORE  8'h24
`define DA_R_AUX    3'h2
// ==========================================
// Command word fields
`define DA_F_OP     5:0
`define DA_F_SH     9:6
`define DA_F_IND    10
`define DA_F_MODE   13:11
`define DA_F_LDSEL  14
`define DA_F_NSEL   17:15
`define DA_F_OFS    24:18
`define DA_F_K8     25:18
`define DA_F_OFF    26
// ==========================================
// Operation codes
`define DA_OP_ADD   6'h01
`define DA_OP_ADD_WITH_CARRY  6'h02
`define DA_OP_ADD_HIGH_HALF  6'h03
`define DA_OP_ADD_SHORT_CONST  6'h04
`define DA_OP_ADD_UNSIGNED_LOW  6'h05
`define DA_OP_ADD_TSHIFT  6'h06
`define DA_OP_ADLK  6'h07
`define DA_OP_AND   6'h08
`define DA_OP_AND_LONG_CONST  6'h09
`define DA_OP_INVERT_OP  6'h0A
`define DA_OP_LAC   6'h0B
`define DA_OP_LOAD_SHORT_CONST  6'h0C
`define DA_OP_LOAD_TSHIFT  6'h0D
`define DA_OP_LOAD_LONG_CONST  6'h0E
`define DA_OP_NEG   6'h0F
`define DA_OP_OR    6'h10
`define DA_OP_ORK   6'h11
`define DA_OP_STORE_HIGH_HALF  6'h12
`define DA_OP_STORE_LOW_HALF  6'h13
`define DA_OP_SBLK  6'h14
`define DA_OP_SUB   6'h15
`define DA_OP_SUB_WITH_BORROW  6'h16
`define DA_OP_SUB_HIGH_HALF  6'h17
`define DA_OP_SUB_SHORT_CONST  6'h18
`define DA_OP_SUB_UNSIGNED_LOW  6'h19
`define DA_OP_SUB_TSHIFT  6'h1A
`define DA_OP_XOR   6'h1B
`define DA_OP_XOR_LONG_CONST  6'h1C
`define DA_OP_ZAC   6'h1D
`define DA_OP_ZALH  6'h1E
`define DA_OP_LOAD_HIGH_ROUNDED  6'h1F
`define DA_OP_LOAD_LOW_CLEAR_HIGH  6'h20
`define DA_OP_ABS   6'h21
// ==========================================
// Indirect update modes, constants, bus answers
`define DA_M_NONE   3'h0
`define DA_M_INC    3'h1
`define DA_M_DEC    3'h2
`define DA_M_ADD0   3'h3
`define DA_M_SUB0   3'h4
`define DA_M_BRADD  3'h5
`define DA_M_BRSUB  3'h6
`define DA_ROUND    16'h8000
`define DA_EXT_WAIT 2'h2
`define DA_OKAY     2'h0
`define DA_SLVERR   2'h2
`endif

/* File: rtl/da_alu.v */
// Address generator and accumulator datapath with AXI4-Lite registers
`timescale 1ns/1ns
`include "da_alu_consts.vh"
module da_alu (
   input  wire        CLK_SYS_IN,
   input  wire        RST_B_IN,
   input  wire [7:0]  S_AXI_AWADDR_IN,
   input  wire        S_AXI_AWVALID_IN,
   output wire        S_AXI_AWREADY_OUT,
   input  wire [31:0] S_AXI_WDATA_IN,
   input  wire [3:0]  S_AXI_WSTRB_IN,
   input  wire        S_AXI_WVALID_IN,
   output wire        S_AXI_WREADY_OUT,
   output wire [1:0]  S_AXI_BRESP_OUT,
   output wire        S_AXI_BVALID_OUT,
   input  wire        S_AXI_BREADY_IN,
   input  wire [7:0]  S_AXI_ARADDR_IN,
   input  wire        S_AXI_ARVALID_IN,
   output wire        S_AXI_ARREADY_OUT,
   output wire [31:0] S_AXI_RDATA_OUT,
   output wire [1:0]  S_AXI_RRESP_OUT,
   output wire        S_AXI_RVALID_OUT,
   input  wire        S_AXI_RREADY_IN
);
   // ==========================================
   // Functions
   // Mirror a 16-bit word end for end
   function [15:0] rev16;
      input [15:0] v;
      integer i;
      begin
         for (i = 0; i < 16; i = i + 1) begin
            rev16[i] = v[15 - i];
         end
      end
   endfunction

   // Merge write data into an old value under byte strobes
   function [31:0] wmerge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer j;
      begin
         for (j = 0; j < 4; j = j + 1) begin
            wmerge[j*8 +: 8] = strb[j] ? nw[j*8 +: 8] : old[j*8 +: 8];
         end
      end
   endfunction

   // ==========================================
   // Architectural state
   reg [15:0] opnd_reg;        // Data word or long constant for next command
   reg [8:0]  page_reg;        // page_pointer
   reg [2:0]  sel_reg;         // aux_select
   reg [15:0] treg_reg;        // Temporary register, low four bits shift
   reg        sxm_reg;         // Sign extension enable
   reg        carry_reg;       // Carry bit
   reg [31:0] accum_reg;       // accum
   reg [15:0] addr_reg;        // Last data address formed
   reg [15:0] store_reg;       // Last value stored to data memory
   reg [15:0] aux_reg [0:7];   // Auxiliary registers, entry 0 is index_reg_zero

   // ==========================================
   // Pipeline stages
   reg        f_v_reg;         // Fetch stage holds a command
   reg [31:0] f_cmd_reg;
   reg [15:0] f_opd_reg;
   reg        d_v_reg;         // Decode stage holds a command
   reg [31:0] d_cmd_reg;
   reg [15:0] d_opd_reg;
   reg        d_mem_reg;       // Decoded: takes a data memory operand
   reg        e_v_reg;         // Execute stage holds a command
   reg [31:0] e_cmd_reg;
   reg [15:0] e_opd_reg;
   reg        e_mem_reg;
   reg [1:0]  st_cnt_reg;      // Remaining stretch cycles in execute

   // ==========================================
   // Bus slave state
   reg        awready_reg;
   reg        wready_reg;
   reg        aw_full_reg;     // Write address held
   reg        w_full_reg;      // Write data held
   reg [7:0]  awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0]  wstrb_reg;
   reg        bvalid_reg;
   reg [1:0]  bresp_reg;
   reg        arready_reg;
   reg        rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0]  rresp_reg;

   // ==========================================
   // Pipeline control
   // The whole pipe moves as one; it halts only while execute is stretched
   wire e_fire = e_v_reg && (st_cnt_reg == 2'h0);
   wire adv    = !e_v_reg || (st_cnt_reg == 2'h0);
   wire f_can  = !f_v_reg || adv;                     // Fetch slot free

   // Bus write is ready to land; a command waits for a free fetch slot
   wire wr_hit  = aw_full_reg && w_full_reg && !bvalid_reg;
   wire wr_cmd  = wr_hit && (awaddr_reg == `DA_R_CMD);
   wire wr_go   = wr_hit && (!wr_cmd || f_can);
   wire [31:0] wr_word = wmerge(32'h0, wdata_reg, wstrb_reg);

   // Decode class: immediate and operandless ops form no data address
   reg dec_mem;
   always @* begin
      case (f_cmd_reg[`DA_F_OP])
         `DA_OP_ADD_SHORT_CONST, `DA_OP_SUB_SHORT_CONST, `DA_OP_LOAD_SHORT_CONST,
         `DA_OP_ADLK, `DA_OP_SBLK, `DA_OP_LOAD_LONG_CONST,
         `DA_OP_AND_LONG_CONST, `DA_OP_ORK,  `DA_OP_XOR_LONG_CONST,
         `DA_OP_INVERT_OP, `DA_OP_NEG,  `DA_OP_ABS,
         `DA_OP_ZAC: begin
            dec_mem = 1'b0;
         end
         default: begin
            dec_mem = (f_cmd_reg[`DA_F_OP] != 6'h00);
         end
      endcase
   end

   // ==========================================
   // Execute: address generation
   wire [5:0]  e_op   = e_cmd_reg[`DA_F_OP];
   wire [2:0]  e_mode = e_cmd_reg[`DA_F_MODE];
   wire [15:0] cur_aux = aux_reg[sel_reg];
   wire [15:0] idx0    = aux_reg[0];
   wire [15:0] dir_addr = {page_reg, e_cmd_reg[`DA_F_OFS]};
   wire [15:0] eff_addr = e_cmd_reg[`DA_F_IND] ? cur_aux : dir_addr;

   // Post-access update of the selected auxiliary register
   reg [15:0] aux_next;
   always @* begin
      case (e_mode)
         `DA_M_INC:   aux_next = cur_aux + 16'h0001;
         `DA_M_DEC:   aux_next = cur_aux - 16'h0001;
         `DA_M_ADD0:  aux_next = cur_aux + idx0;
         `DA_M_SUB0:  aux_next = cur_aux - idx0;
         // Reversing both sides makes carries run from bit 15 downward
         `DA_M_BRADD: aux_next = rev16(rev16(cur_aux) + rev16(idx0));
         `DA_M_BRSUB: aux_next = rev16(rev16(cur_aux) - rev16(idx0));
         default:     aux_next = cur_aux;
      endcase
   end

   // ==========================================
   // Execute: operand shaping
   wire [15:0] dma   = e_opd_reg;
   wire [31:0] dext  = sxm_reg ? {{16{dma[15]}}, dma} : {16'h0000, dma};
   wire [31:0] dzero = {16'h0000, dma};
   wire        tvar  = (e_op == `DA_OP_ADD_TSHIFT) || (e_op == `DA_OP_SUB_TSHIFT) ||
                       (e_op == `DA_OP_LOAD_TSHIFT);
   wire [3:0]  shcnt = tvar ? treg_reg[3:0] : e_cmd_reg[`DA_F_SH];
   wire [31:0] dsh   = dext << shcnt;
   wire [31:0] ksh   = dext << e_cmd_reg[`DA_F_SH];
   wire [31:0] k8    = {24'h000000, e_cmd_reg[`DA_F_K8]};
   wire [31:0] acsh  = accum_reg << e_cmd_reg[`DA_F_SH];
   wire [31:0] neg_acc = (~accum_reg) + 32'h00000001;

   // ==========================================
   // Execute: accumulator arithmetic and logic
   reg        arith;     // Result comes from the adder
   reg        do_sub;    // Adder subtracts b
   reg [31:0] b;         // Adder operand
   reg        cin;       // Adder carry in
   reg [32:0] sum;       // Adder with carry out
   reg [31:0] res;       // New accumulator
   reg        wr_acc;    // Accumulator written
   reg        wr_st;     // Store result written
   reg [15:0] st_val;    // Value for data memory
   always @* begin
      arith  = 1'b0;
      do_sub = 1'b0;
      b      = 32'h00000000;
      cin    = 1'b0;
      res    = accum_reg;
      wr_acc = 1'b1;
      wr_st  = 1'b0;
      st_val = 16'h0000;
      case (e_op)
         `DA_OP_ADD, `DA_OP_ADD_TSHIFT: begin
            arith = 1'b1; b = dsh;
         end
         `DA_OP_SUB, `DA_OP_SUB_TSHIFT: begin
            arith = 1'b1; do_sub = 1'b1; b = dsh; cin = 1'b1;
         end
         `DA_OP_ADD_WITH_CARRY: begin
            arith = 1'b1; b = dext; cin = carry_reg;
         end
         `DA_OP_SUB_WITH_BORROW: begin
            arith = 1'b1; do_sub = 1'b1; b = dext; cin = carry_reg;
         end
         `DA_OP_ADD_UNSIGNED_LOW: begin
            arith = 1'b1; b = dzero;
         end
         `DA_OP_SUB_UNSIGNED_LOW: begin
            arith = 1'b1; do_sub = 1'b1; b = dzero; cin = 1'b1;
         end
         `DA_OP_ADD_HIGH_HALF: begin
            arith = 1'b1; b = {dma, 16'h0000};
         end
         `DA_OP_SUB_HIGH_HALF: begin
            arith = 1'b1; do_sub = 1'b1; b = {dma, 16'h0000}; cin = 1'b1;
         end
         `DA_OP_ADD_SHORT_CONST: begin
            arith = 1'b1; b = k8;
         end
         `DA_OP_SUB_SHORT_CONST: begin
            arith = 1'b1; do_sub = 1'b1; b = k8; cin = 1'b1;
         end
         `DA_OP_ADLK: begin
            arith = 1'b1; b = ksh;
         end
         `DA_OP_SBLK: begin
            arith = 1'b1; do_sub = 1'b1; b = ksh; cin = 1'b1;
         end
         `DA_OP_LAC, `DA_OP_LOAD_TSHIFT: res = dsh;
         `DA_OP_LOAD_SHORT_CONST: res = k8;
         `DA_OP_LOAD_LONG_CONST: res = {dma, 16'h0000};
         `DA_OP_AND:  res = {16'h0000, accum_reg[15:0] & dma};
         `DA_OP_OR:   res = {accum_reg[31:16], accum_reg[15:0] | dma};
         `DA_OP_XOR:  res = {accum_reg[31:16], accum_reg[15:0] ^ dma};
         // Bit 31 is kept as it was
         `DA_OP_AND_LONG_CONST: res = {accum_reg[31], accum_reg[30:0] & ksh[30:0]};
         `DA_OP_ORK:  res = {accum_reg[31], accum_reg[30:0] | ksh[30:0]};
         `DA_OP_XOR_LONG_CONST: res = {accum_reg[31], accum_reg[30:0] ^ ksh[30:0]};
         `DA_OP_INVERT_OP: res = ~accum_reg;
         `DA_OP_NEG:  res = neg_acc;
         `DA_OP_ABS:  res = accum_reg[31] ? neg_acc : accum_reg;
         `DA_OP_ZAC:  res = 32'h00000000;
         `DA_OP_ZALH: res = {dma, 16'h0000};
         `DA_OP_LOAD_HIGH_ROUNDED: res = {dma, `DA_ROUND};
         `DA_OP_LOAD_LOW_CLEAR_HIGH: res = {16'h0000, dma};
         `DA_OP_STORE_HIGH_HALF: begin
            wr_acc = 1'b0; wr_st = 1'b1; st_val = acsh[31:16];
         end
         `DA_OP_STORE_LOW_HALF: begin
            wr_acc = 1'b0; wr_st = 1'b1; st_val = acsh[15:0];
         end
         default: wr_acc = 1'b0;
      endcase
      // Subtract is add of the inverse; carry out is then not-borrow
      sum = {1'b0, accum_reg} + {1'b0, (do_sub ? ~b : b)} + {32'h00000000, cin};
      if (arith) begin
         res = sum[31:0];
      end
   end

   // ==========================================
   // Read data multiplexer
   reg [31:0] rd_word;
   reg        rd_bad;
   always @* begin
      rd_word = 32'h00000000;
      rd_bad  = 1'b0;
      if (S_AXI_ARADDR_IN[7:5] == `DA_R_AUX) begin
         rd_word = {16'h0000, aux_reg[S_AXI_ARADDR_IN[4:2]]};
      end else begin
         case (S_AXI_ARADDR_IN)
            `DA_R_CMD:   rd_word = f_cmd_reg;
            `DA_R_OPND:  rd_word = {16'h0000, opnd_reg};
            `DA_R_PAGE:  rd_word = {23'h000000, page_reg};
            `DA_R_SEL:   rd_word = {29'h00000000, sel_reg};
            `DA_R_TREG:  rd_word = {16'h0000, treg_reg};
            `DA_R_CTRL:  rd_word = {31'h00000000, sxm_reg};
            `DA_R_STAT:  rd_word = {29'h00000000, (st_cnt_reg != 2'h0),
                                    (f_v_reg | d_v_reg | e_v_reg), carry_reg};
            `DA_R_ACC:   rd_word = accum_reg;
            `DA_R_ADDR:  rd_word = {16'h0000, addr_reg};
            `DA_R_STORE: rd_word = {16'h0000, store_reg};
            default:     rd_bad  = 1'b1;
         endcase
      end
   end

   // Address decode for the write side
   wire wr_aux = (awaddr_reg[7:5] == `DA_R_AUX);
   reg  wr_bad;
   always @* begin
      case (awaddr_reg)
         `DA_R_CMD, `DA_R_OPND, `DA_R_PAGE, `DA_R_SEL, `DA_R_TREG,
         `DA_R_CTRL, `DA_R_STAT, `DA_R_ACC: wr_bad = 1'b0;
         default: wr_bad = !wr_aux;
      endcase
   end

   // ==========================================
   // AXI4-Lite handshakes
   // Address and data are caught apart; a command write waits for the pipe
   always @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         aw_full_reg <= 1'b0;
         w_full_reg  <= 1'b0;
         awaddr_reg  <= 8'h00;
         wdata_reg   <= 32'h00000000;
         wstrb_reg   <= 4'h0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `DA_OKAY;
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h00000000;
         rresp_reg   <= `DA_OKAY;
      end else begin
         // Write address channel
         if (S_AXI_AWVALID_IN && awready_reg) begin
            awaddr_reg  <= S_AXI_AWADDR_IN;
            aw_full_reg <= 1'b1;
            awready_reg <= 1'b0;
         end
         // Write data channel
         if (S_AXI_WVALID_IN && wready_reg) begin
            wdata_reg  <= S_AXI_WDATA_IN;
            wstrb_reg  <= S_AXI_WSTRB_IN;
            w_full_reg <= 1'b1;
            wready_reg <= 1'b0;
         end
         // Response once both halves have landed
         if (wr_go) begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_bad ? `DA_SLVERR : `DA_OKAY;
         end
         // Channels reopen only after the response is taken
         if (bvalid_reg && S_AXI_BREADY_IN) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
         // Read: one outstanding, answered the next cycle
         if (S_AXI_ARVALID_IN && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_word;
            rresp_reg   <= rd_bad ? `DA_SLVERR : `DA_OKAY;
         end
         if (rvalid_reg && S_AXI_RREADY_IN) begin
            rvalid_reg  <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // ==========================================
   // Pipeline stage registers
   always @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         f_v_reg    <= 1'b0;
         f_cmd_reg  <= 32'h00000000;
         f_opd_reg  <= 16'h0000;
         d_v_reg    <= 1'b0;
         d_cmd_reg  <= 32'h00000000;
         d_opd_reg  <= 16'h0000;
         d_mem_reg  <= 1'b0;
         e_v_reg    <= 1'b0;
         e_cmd_reg  <= 32'h00000000;
         e_opd_reg  <= 16'h0000;
         e_mem_reg  <= 1'b0;
         st_cnt_reg <= 2'h0;
      end else begin
         if (adv) begin
            // Execute takes decode, decode takes fetch
            e_v_reg   <= d_v_reg;
            e_cmd_reg <= d_cmd_reg;
            e_opd_reg <= d_opd_reg;
            e_mem_reg <= d_mem_reg;
            d_v_reg   <= f_v_reg;
            d_cmd_reg <= f_cmd_reg;
            d_opd_reg <= f_opd_reg;
            d_mem_reg <= dec_mem;
            f_v_reg   <= 1'b0;
            // Off-chip operand shares the data lines with program fetch
            st_cnt_reg <= (d_v_reg && d_mem_reg && d_cmd_reg[`DA_F_OFF]) ?
                          `DA_EXT_WAIT : 2'h0;
         end else begin
            st_cnt_reg <= st_cnt_reg - 2'h1;
         end
         // New command latches the operand word alongside it
         if (wr_go && wr_cmd) begin
            f_v_reg   <= 1'b1;
            f_cmd_reg <= wr_word;
            f_opd_reg <= opnd_reg;
         end
      end
   end

   // ==========================================
   // Architectural registers: execute wins over a bus write
   integer k;
   always @(posedge CLK_SYS_IN) begin
      if (!RST_B_IN) begin
         opnd_reg  <= 16'h0000;
         page_reg  <= 9'h000;
         sel_reg   <= 3'h0;
         treg_reg  <= 16'h0000;
         sxm_reg   <= 1'b1;
         carry_reg <= 1'b0;
         accum_reg <= 32'h00000000;
         addr_reg  <= 16'h0000;
         store_reg <= 16'h0000;
         for (k = 0; k < 8; k = k + 1) begin
            aux_reg[k] <= 16'h0000;
         end
      end else begin
         // Software writes
         if (wr_go && !wr_bad) begin
            if (wr_aux) begin
               aux_reg[awaddr_reg[4:2]] <= wr_word[15:0];
            end
            case (awaddr_reg)
               `DA_R_OPND: opnd_reg  <= wr_word[15:0];
               `DA_R_PAGE: page_reg  <= wr_word[8:0];
               `DA_R_SEL:  sel_reg   <= wr_word[2:0];
               `DA_R_TREG: treg_reg  <= wr_word[15:0];
               `DA_R_CTRL: sxm_reg   <= wr_word[0];
               `DA_R_STAT: carry_reg <= wr_word[0];
               `DA_R_ACC:  accum_reg <= wr_word;
               default: begin
               end
            endcase
         end
         // Execute results
         if (e_fire) begin
            if (e_mem_reg) begin
               addr_reg <= eff_addr;
               if (e_cmd_reg[`DA_F_IND]) begin
                  aux_reg[sel_reg] <= aux_next;
                  if (e_cmd_reg[`DA_F_LDSEL]) begin
                     sel_reg <= e_cmd_reg[`DA_F_NSEL];
                  end
               end
            end
            if (wr_acc) begin
               accum_reg <= res;
            end
            if (arith) begin
               carry_reg <= sum[32];
            end
            if (wr_st) begin
               store_reg <= st_val;
            end
         end
      end
   end

   // ==========================================
   // Outputs, all from flip-flops
   assign S_AXI_AWREADY_OUT = awready_reg;
   assign S_AXI_WREADY_OUT  = wready_reg;
   assign S_AXI_BRESP_OUT   = bresp_reg;
   assign S_AXI_BVALID_OUT  = bvalid_reg;
   assign S_AXI_ARREADY_OUT = arready_reg;
   assign S_AXI_RDATA_OUT   = rdata_reg;
   assign S_AXI_RRESP_OUT   = rresp_reg;
   assign S_AXI_RVALID_OUT  = rvalid_reg;
endmodule

/* File: dv/da_bus_mst.sv */
// Register bus master model
`timescale 1ns/1ns
module da_bus_mst (
   input  wire        clk, awrdy, wrdy, bv, arrdy, rv,
   input  wire [1:0]  rr,
   input  wire [31:0] rd_d,
   output reg  [7:0]  awa = 8'h00, ara = 8'h00,
   output reg  [31:0] wd = 32'h0,
   output reg         awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0
);
   // Address and data offered together, each dropped once taken
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         awa <= a;
         wd <= d;
         {awv, wv, brdy} <= 3'b111;
         do begin
            @(posedge clk);
            if (awrdy) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
         end while (!bv);
         brdy <= 1'b0;
      end
   endtask
   // Read data and response taken at the edge where valid is seen
   task rd(input [7:0] a, output [31:0] d, output [1:0] r);
      begin
         @(posedge clk);
         ara <= a;
         {arv, rrdy} <= 2'b11;
         do begin
            @(posedge clk);
            if (arrdy) arv <= 1'b0;
         end while (!rv);
         rrdy <= 1'b0;
         d = rd_d;
         r = rr;
      end
   endtask
endmodule

/* File: dv/da_alu_properties.sv */
// Bus handshake checks for the datapath block
`timescale 1ns/1ns
module da_alu_properties (
   input wire        CLK_SYS_IN, RST_B_IN, S_AXI_ARVALID_IN, S_AXI_ARREADY_OUT,
   input wire        S_AXI_RVALID_OUT, S_AXI_RREADY_IN, S_AXI_BVALID_OUT,
   input wire        S_AXI_BREADY_IN, S_AXI_AWREADY_OUT,
   input wire [7:0]  S_AXI_ARADDR_IN,
   input wire [31:0] S_AXI_RDATA_OUT,
   input wire [1:0]  S_AXI_RRESP_OUT, S_AXI_BRESP_OUT
);
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (!RST_B_IN);
   // Read address accepted
   sequence ar_take;
      S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT;
   endsequence
   a_read_answer: assert property (ar_take |=> S_AXI_RVALID_OUT && !S_AXI_ARREADY_OUT)
      else $error("read answer not next cycle");
   a_rdata_hold: assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=>
      S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT) && $stable(S_AXI_RRESP_OUT))
      else $error("read answer moved");
   a_read_close: assert property (S_AXI_RVALID_OUT && S_AXI_RREADY_IN |=>
      !S_AXI_RVALID_OUT && S_AXI_ARREADY_OUT) else $error("read not closed");
   a_bresp_hold: assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=>
      S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT)) else $error("write answer moved");
   a_write_close: assert property (S_AXI_BVALID_OUT && S_AXI_BREADY_IN |=>
      !S_AXI_BVALID_OUT && S_AXI_AWREADY_OUT) else $error("write not closed");
   a_unmapped_read: assert property (ar_take and S_AXI_ARADDR_IN == 8'h3C |=>
      S_AXI_RRESP_OUT == 2'h2 && S_AXI_RDATA_OUT == 32'h0) else $error("bad refusal");
   a_mapped_read: assert property (ar_take and S_AXI_ARADDR_IN == 8'h1C |=>
      S_AXI_RRESP_OUT == 2'h0) else $error("mapped read refused");
   a_reset_idle: assert property (disable iff (1'b0) !RST_B_IN |=>
      !S_AXI_BVALID_OUT && !S_AXI_RVALID_OUT) else $error("busy after reset");
endmodule
bind da_alu da_alu_properties chk (.CLK_SYS_IN, .RST_B_IN, .S_AXI_ARVALID_IN,
   .S_AXI_ARREADY_OUT, .S_AXI_RVALID_OUT, .S_AXI_RREADY_IN, .S_AXI_BVALID_OUT,
   .S_AXI_BREADY_IN, .S_AXI_AWREADY_OUT, .S_AXI_ARADDR_IN, .S_AXI_RDATA_OUT,
   .S_AXI_RRESP_OUT, .S_AXI_BRESP_OUT);

/* File: dv/da_alu_tb.sv */
// Self-checking bench for the datapath block
`timescale 1ns/1ns
`include "da_alu_consts.vh"
module da_alu_tb;
   reg         clk = 1'b0, rst_b = 1'b0;
   wire [7:0]  awa, ara;
   wire [31:0] wd, rd_d;
   wire [1:0]  br, rr;
   wire        awv, awrdy, wv, wrdy, bv, brdy, arv, arrdy, rv, rrdy;
   integer     errors = 0, num_checks = 0;
   reg  [31:0] got;
   reg  [1:0]  resp;
   always #4 clk = ~clk;
   da_alu dut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .S_AXI_AWADDR_IN(awa),
      .S_AXI_AWVALID_IN(awv), .S_AXI_AWREADY_OUT(awrdy), .S_AXI_WDATA_IN(wd),
      .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
      .S_AXI_BRESP_OUT(br), .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(brdy),
      .S_AXI_ARADDR_IN(ara), .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arrdy),
      .S_AXI_RDATA_OUT(rd_d), .S_AXI_RRESP_OUT(rr), .S_AXI_RVALID_OUT(rv),
      .S_AXI_RREADY_IN(rrdy));
   da_bus_mst m (.clk(clk), .awrdy(awrdy), .wrdy(wrdy), .bv(bv), .arrdy(arrdy),
      .rv(rv), .rr(rr), .rd_d(rd_d), .awa(awa), .ara(ara), .wd(wd), .awv(awv),
      .wv(wv), .brdy(brdy), .arv(arv), .rrdy(rrdy));
   task cmp(input [31:0] g, input [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (g !== e) begin
            errors = errors + 1;
            $display("[ERR] %0t got %h want %h", $time, g, e);
         end
      end
   endtask
   task chk(input [7:0] a, input [31:0] e);
      begin
         m.rd(a, got, resp);
         cmp(got, e);
      end
   endtask
   // Operand then command; results settle well inside eight cycles
   task op(input [31:0] d, input [31:0] c);
      begin
         m.wr(`DA_R_OPND, d);
         m.wr(`DA_R_CMD, c);
         repeat (8) @(posedge clk);
      end
   endtask
   task t_direct;
      begin
         m.wr(`DA_R_PAGE, 32'h000001A5);
         op(32'h00001234, 32'h0154010B);
         chk(`DA_R_ACC, 32'h00012340);
         chk(`DA_R_ADDR, 32'h0000D2D5);
         op(32'h00000002, 32'h00000003);
         chk(`DA_R_ACC, 32'h00032340);
         op(32'h0000ABCD, 32'h0000001F);
         chk(`DA_R_ACC, 32'hABCD8000);
         op(32'h00008001, 32'h00000020);
         chk(`DA_R_ACC, 32'h00008001);
         op(32'h00007FFF, 32'h0000000E);
         chk(`DA_R_ACC, 32'h7FFF0000);
         op(32'h00000000, 32'h0000000F);
         chk(`DA_R_ACC, 32'h80010000);
      end
   endtask
   task t_carry;
      begin
         m.wr(`DA_R_ACC, 32'hFFFFFFFF);
         m.wr(`DA_R_STAT, 32'h00000001);
         op(32'h00000000, 32'h00000002);
         chk(`DA_R_ACC, 32'h00000000);
         chk(`DA_R_STAT, 32'h00000001);
         op(32'h00000000, 32'h03FC0004);
         chk(`DA_R_ACC, 32'h000000FF);
      end
   endtask
   task t_indirect;
      begin
         m.wr(`DA_R_SEL, 32'h00000003);
         m.wr(8'h4C, 32'h00000010);
         op(32'h00000005, 32'h0002CC0B);
         chk(`DA_R_ADDR, 32'h00000010);
         chk(8'h4C, 32'h00000011);
         chk(`DA_R_SEL, 32'h00000005);
         m.wr(8'h40, 32'h00000008);
         m.wr(8'h54, 32'h00000008);
         op(32'h00000005, 32'h00002C0B);
         chk(8'h54, 32'h00000004);
         m.rd(8'h3C, got, resp);
         cmp(got, 32'h00000000);
         cmp({30'h0, resp}, 32'h00000002);
      end
   endtask
   // Off-chip store stretches execute; accumulator must survive the store
   task t_store;
      begin
         m.wr(`DA_R_ACC, 32'h12345678);
         op(32'h00000000, 32'h04000112);
         chk(`DA_R_STORE, 32'h00002345);
         chk(`DA_R_ACC, 32'h12345678);
         chk(`DA_R_ADDR, 32'h0000D280);
         m.wr(`DA_R_TREG, 32'h00000003);
         op(32'h00000001, 32'h00000006);
         chk(`DA_R_ACC, 32'h12345680);
         op(32'h00008001, 32'h00000005);
         chk(`DA_R_ACC, 32'h1234D681);
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d errors %0d", num_checks, errors);
         if (errors == 0 && num_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial begin
      #100000;
      errors = errors + 1;
      tally_and_finish;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      t_direct;
      t_carry;
      t_indirect;
      t_store;
      tally_and_finish;
   end
endmodule
